// [design/acb_pkg.sv]
package acb_pkg;
   // register offsets on the serial port (13-bit address space)
   localparam logic [12:0] ADDR_DEVICE_INDEX_A = 13'h0004;
   localparam logic [12:0] ADDR_DEVICE_INDEX_B = 13'h0005;
   localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
   localparam logic [12:0] ADDR_CLOCK_COND = 13'h0009;
   localparam logic [12:0] ADDR_CLOCK_DIVIDER = 13'h000B;
   localparam logic [12:0] ADDR_ENHANCEMENT = 13'h000C;
   localparam logic [12:0] ADDR_OUTPUT_MODE = 13'h0014;
   localparam logic [12:0] ADDR_OUTPUT_ADJUST = 13'h0015;
   localparam logic [12:0] ADDR_OUTPUT_PHASE = 13'h0016;
   localparam logic [12:0] ADDR_SERIALISATION = 13'h0021;
   localparam logic [12:0] ADDR_UPDATE_COMMIT = 13'h00FF;
   localparam logic [12:0] ADDR_RATE_OVERRIDE = 13'h0100;
   localparam logic [12:0] ADDR_PIN_CONTROL_TWO = 13'h0101;

   // writable bit masks; open positions are zero
   localparam logic [7:0] MASK_DEVICE_INDEX_A = 8'h0F;
   localparam logic [7:0] MASK_DEVICE_INDEX_B = 8'h3F;
   localparam logic [7:0] MASK_POWER_MODE = 8'h23;
   localparam logic [7:0] MASK_CLOCK_COND = 8'h01;
   localparam logic [7:0] MASK_CLOCK_DIVIDER = 8'h07;
   localparam logic [7:0] MASK_ENHANCEMENT = 8'h04;
   localparam logic [7:0] MASK_OUTPUT_MODE = 8'h45;
   localparam logic [7:0] MASK_OUTPUT_ADJUST = 8'h31;
   localparam logic [7:0] MASK_OUTPUT_PHASE = 8'h7F;
   localparam logic [7:0] MASK_SERIALISATION = 8'hF7;
   localparam logic [7:0] MASK_RATE_OVERRIDE = 8'h47;
   localparam logic [7:0] MASK_PIN_CONTROL_TWO = 8'h01;

   // reset values
   localparam logic [7:0] RESET_DEVICE_INDEX_A = 8'h0F;
   localparam logic [7:0] RESET_DEVICE_INDEX_B = 8'h3F;
   localparam logic [7:0] RESET_POWER_MODE = 8'h00;
   localparam logic [7:0] RESET_CLOCK_COND = 8'h01;
   localparam logic [7:0] RESET_CLOCK_DIVIDER = 8'h00;
   localparam logic [7:0] RESET_ENHANCEMENT = 8'h00;
   localparam logic [7:0] RESET_OUTPUT_MODE = 8'h01;
   localparam logic [7:0] RESET_OUTPUT_ADJUST = 8'h00;
   localparam logic [7:0] RESET_OUTPUT_PHASE = 8'h03;
   localparam logic [7:0] RESET_SERIALISATION = 8'h30;
   localparam logic [7:0] RESET_RATE_OVERRIDE = 8'h00;
   localparam logic [7:0] RESET_PIN_CONTROL_TWO = 8'h00;

   // field positions
   localparam int POS_PIN_STANDBY = 5;
   localparam int POS_MODE_LO = 0;
   localparam int POS_STABILISER = 0;
   localparam int POS_CHOP = 2;
   localparam int POS_REDUCED_RANGE = 6;
   localparam int POS_INVERT = 2;
   localparam int POS_TWOS = 0;
   localparam int POS_TERM_LO = 4;
   localparam int POS_DRIVE_2X = 0;
   localparam int POS_IN_PHASE_LO = 4;
   localparam int POS_OUT_PHASE_LO = 0;
   localparam int POS_COMMIT = 0;
   localparam int POS_OVERRIDE_EN = 6;
   localparam int POS_RATE_LO = 0;
   localparam int POS_PULLDOWN_OFF = 0;
   localparam int POS_FCO_SELECT = 5;
   localparam int POS_DCO_SELECT = 4;
   localparam logic [3:0] OUT_PHASE_MAX = 4'hB;

   // power mode codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_POWER_DOWN = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_DIGITAL_RESET = 2'h3;

   localparam int INSTR_BITS = 16;
   localparam int DATA_BITS = 8;

   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_INSTR,
      SPI_DATA
   } acb_spi_state_type;
endpackage

// [design/acb_sample_divider.sv]
`timescale 1ns/10ps
`default_nettype none
// sample strobe from the applied clock, divided and phase shifted
module acb_sample_divider
   import acb_pkg::*;
#(
   parameter int RATIO_WIDTH = 3
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic hold_reset,
   input wire logic [RATIO_WIDTH-1:0] ratio,
   input wire logic [RATIO_WIDTH-1:0] phase,
   output logic sample_strobe
);
   logic [RATIO_WIDTH-1:0] count;
   logic [RATIO_WIDTH-1:0] next_count;
   logic [RATIO_WIDTH-1:0] eff_phase;

   always_comb begin
      next_count = (count >= ratio) ? '0 : count + 1'b1;
   end

   // phase has meaning only when dividing; a phase beyond the ratio never matches
   assign eff_phase = (ratio == '0) ? '0 : phase;

   always_ff @(posedge sys_clk) begin
      if (rst || hold_reset) begin
         count <= '0;
      end else if (run) begin
         count <= next_count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || hold_reset) begin
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= run && (count == eff_phase);
      end
   end
endmodule // acb_sample_divider
`default_nettype wire

// [design/acb_config_bank.sv]
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank
   import acb_pkg::*;
#(
   parameter int ADDR_WIDTH = 13
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdio_in,
   output logic spi_sdio_out,
   output logic spi_sdio_oe,
   input wire logic power_down_pin,
   input wire logic pin_config_mode,
   output logic datapath_clock_enable,
   output logic datapath_reset,
   output logic outputs_enable,
   output logic stabiliser_enable,
   output logic chop_enable,
   output logic reduced_range_output,
   output logic output_invert,
   output logic twos_complement,
   output logic [1:0] termination_select,
   output logic frame_clock_out_2x,
   output logic data_clock_out_2x,
   output logic [3:0] data_clock_out_phase,
   output logic [2:0] input_clock_phase,
   output logic sample_strobe,
   output logic [7:0] serialisation_mode,
   output logic rate_override_enable,
   output logic [2:0] rate_override_code,
   output logic sdio_pulldown_enable,
   output logic [3:0] channel_select
);
   logic [7:0] device_index_a;
   logic [7:0] device_index_b;
   logic [7:0] power_mode_control;
   logic [7:0] clock_conditioning;
   logic [7:0] clock_divider;
   logic [7:0] enhancement_control;
   logic [7:0] output_mode_control;
   logic [7:0] output_adjust_control;
   logic [7:0] output_phase_control;
   logic [7:0] serialisation_control;
   logic [7:0] rate_capability_override;
   logic [7:0] rate_override_active;
   logic [7:0] pin_control_two;

   acb_spi_state_type spi_state;
   logic sclk_prev;
   logic sclk_rise;
   logic sclk_fall;
   logic [3:0] bit_count;
   logic [15:0] instr_shift;
   logic [7:0] data_shift;
   logic [7:0] read_shift;
   logic read_access;
   logic [ADDR_WIDTH-1:0] access_addr;
   logic wr_strobe;
   logic [ADDR_WIDTH-1:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] read_data;
   logic [1:0] effective_mode;

   // open positions are dropped on the way in
   function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
      masked = value & mask;
   endfunction

   // readback of every mapped register; anything else reads zero
   function automatic logic [7:0] register_read(input logic [ADDR_WIDTH-1:0] addr);
      case (addr)
         ADDR_DEVICE_INDEX_A: register_read = device_index_a;
         ADDR_DEVICE_INDEX_B: register_read = device_index_b;
         ADDR_POWER_MODE: register_read = power_mode_control;
         ADDR_CLOCK_COND: register_read = clock_conditioning;
         ADDR_CLOCK_DIVIDER: register_read = clock_divider;
         ADDR_ENHANCEMENT: register_read = enhancement_control;
         ADDR_OUTPUT_MODE: register_read = output_mode_control;
         ADDR_OUTPUT_ADJUST: register_read = output_adjust_control;
         ADDR_OUTPUT_PHASE: register_read = output_phase_control;
         ADDR_SERIALISATION: register_read = serialisation_control;
         ADDR_RATE_OVERRIDE: register_read = rate_capability_override;
         ADDR_PIN_CONTROL_TWO: register_read = pin_control_two;
         default: register_read = 8'h00;
      endcase
   endfunction

   assign sclk_rise = spi_sclk && !sclk_prev;
   assign sclk_fall = !spi_sclk && sclk_prev;
   // a process rather than an assign, so a register change behind the same address is seen
   always_comb begin
      read_data = register_read(access_addr);
   end

   // serial port: only the global reset reaches it, never the digital reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= spi_sclk;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || spi_csb_n) begin
         spi_state <= SPI_IDLE;
         bit_count <= 4'h0;
         instr_shift <= 16'h0000;
         data_shift <= 8'h00;
         read_access <= 1'b0;
         access_addr <= '0;
      end else begin
         case (spi_state)
            SPI_IDLE: begin
               spi_state <= SPI_INSTR;
               bit_count <= 4'h0;
            end
            SPI_INSTR: begin
               if (sclk_rise) begin
                  instr_shift <= {instr_shift[14:0], spi_sdio_in};
                  bit_count <= bit_count + 4'h1;
                  if (bit_count == 4'(INSTR_BITS - 1)) begin
                     read_access <= instr_shift[14];
                     access_addr <= {instr_shift[11:0], spi_sdio_in};
                     bit_count <= 4'h0;
                     spi_state <= SPI_DATA;
                  end
               end
            end
            SPI_DATA: begin
               if (sclk_rise) begin
                  data_shift <= {data_shift[6:0], spi_sdio_in};
                  bit_count <= bit_count + 4'h1;
                  if (bit_count == 4'(DATA_BITS - 1)) begin
                     bit_count <= 4'h0;
                     // streaming walks downward through the map
                     access_addr <= access_addr - 1'b1;
                  end
               end
            end
            default: spi_state <= SPI_IDLE;
         endcase
      end
   end

   // write pulse one cycle after the last data bit is taken
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_strobe <= 1'b0;
         wr_addr <= '0;
         wr_data <= 8'h00;
      end else begin
         wr_strobe <= !spi_csb_n && spi_state == SPI_DATA && sclk_rise && !read_access
                      && bit_count == 4'(DATA_BITS - 1);
         wr_addr <= access_addr;
         wr_data <= {data_shift[6:0], spi_sdio_in};
      end
   end

   // read data leaves msb first on falling clock edges
   always_ff @(posedge sys_clk) begin
      if (rst || spi_csb_n) begin
         read_shift <= 8'h00;
         spi_sdio_out <= 1'b0;
      end else if (spi_state == SPI_DATA && read_access && sclk_fall) begin
         if (bit_count == 4'h0) begin
            spi_sdio_out <= read_data[7];
            read_shift <= {read_data[6:0], 1'b0};
         end else begin
            spi_sdio_out <= read_shift[7];
            read_shift <= {read_shift[6:0], 1'b0};
         end
      end
   end

   assign spi_sdio_oe = !spi_csb_n && spi_state == SPI_DATA && read_access;

   // configuration registers take their value on the write itself
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         device_index_a <= RESET_DEVICE_INDEX_A;
         device_index_b <= RESET_DEVICE_INDEX_B;
         power_mode_control <= RESET_POWER_MODE;
         clock_conditioning <= RESET_CLOCK_COND;
         clock_divider <= RESET_CLOCK_DIVIDER;
         enhancement_control <= RESET_ENHANCEMENT;
         output_mode_control <= RESET_OUTPUT_MODE;
         output_adjust_control <= RESET_OUTPUT_ADJUST;
         output_phase_control <= RESET_OUTPUT_PHASE;
         serialisation_control <= RESET_SERIALISATION;
         rate_capability_override <= RESET_RATE_OVERRIDE;
         pin_control_two <= RESET_PIN_CONTROL_TWO;
      end else if (wr_strobe) begin
         case (wr_addr)
            ADDR_DEVICE_INDEX_A: device_index_a <= masked(wr_data, MASK_DEVICE_INDEX_A);
            ADDR_DEVICE_INDEX_B: device_index_b <= masked(wr_data, MASK_DEVICE_INDEX_B);
            ADDR_POWER_MODE: power_mode_control <= masked(wr_data, MASK_POWER_MODE);
            ADDR_CLOCK_COND: clock_conditioning <= masked(wr_data, MASK_CLOCK_COND);
            ADDR_CLOCK_DIVIDER: clock_divider <= masked(wr_data, MASK_CLOCK_DIVIDER);
            ADDR_ENHANCEMENT: enhancement_control <= masked(wr_data, MASK_ENHANCEMENT);
            ADDR_OUTPUT_MODE: output_mode_control <= masked(wr_data, MASK_OUTPUT_MODE);
            ADDR_OUTPUT_ADJUST: output_adjust_control <= masked(wr_data, MASK_OUTPUT_ADJUST);
            ADDR_OUTPUT_PHASE: begin
               // codes above the table would name no phase, so the clock field keeps its value
               if (wr_data[POS_OUT_PHASE_LO +: 4] <= OUT_PHASE_MAX) begin
                  output_phase_control <= masked(wr_data, MASK_OUTPUT_PHASE);
               end else begin
                  output_phase_control <= {1'b0, wr_data[POS_IN_PHASE_LO +: 3],
                                           output_phase_control[POS_OUT_PHASE_LO +: 4]};
               end
            end
            ADDR_SERIALISATION: serialisation_control <= masked(wr_data, MASK_SERIALISATION);
            ADDR_RATE_OVERRIDE: rate_capability_override <= masked(wr_data, MASK_RATE_OVERRIDE);
            ADDR_PIN_CONTROL_TWO: pin_control_two <= masked(wr_data, MASK_PIN_CONTROL_TWO);
            default: begin
            end
         endcase
      end
   end

   // staged override goes live only on the commit bit; the commit reads back zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rate_override_active <= RESET_RATE_OVERRIDE;
      end else if (wr_strobe && wr_addr == ADDR_UPDATE_COMMIT && wr_data[POS_COMMIT]) begin
         rate_override_active <= rate_capability_override;
      end
   end

   // the pin only acts from normal mode; a programmed mode is never relaxed by it
   always_comb begin
      effective_mode = power_mode_control[POS_MODE_LO +: 2];
      if (power_down_pin && effective_mode == MODE_NORMAL) begin
         effective_mode = power_mode_control[POS_PIN_STANDBY] ? MODE_STANDBY
                                                              : MODE_POWER_DOWN;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         datapath_clock_enable <= 1'b0;
         datapath_reset <= 1'b1;
         outputs_enable <= 1'b0;
      end else begin
         case (effective_mode)
            MODE_NORMAL: begin
               datapath_clock_enable <= 1'b1;
               datapath_reset <= 1'b0;
               outputs_enable <= 1'b1;
            end
            MODE_POWER_DOWN: begin
               datapath_clock_enable <= 1'b0;
               datapath_reset <= 1'b1;
               outputs_enable <= 1'b0;
            end
            MODE_STANDBY: begin
               datapath_clock_enable <= 1'b0;
               datapath_reset <= 1'b0;
               outputs_enable <= 1'b0;
            end
            MODE_DIGITAL_RESET: begin
               datapath_clock_enable <= 1'b1;
               datapath_reset <= 1'b1;
               outputs_enable <= 1'b0;
            end
            default: begin
               datapath_clock_enable <= 1'b0;
               datapath_reset <= 1'b1;
               outputs_enable <= 1'b0;
            end
         endcase
      end
   end

   // decoded controls, all from flip-flops
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stabiliser_enable <= 1'b0;
         chop_enable <= 1'b0;
         reduced_range_output <= 1'b0;
         output_invert <= 1'b0;
         twos_complement <= 1'b1;
         termination_select <= 2'h0;
         frame_clock_out_2x <= 1'b0;
         data_clock_out_2x <= 1'b0;
         data_clock_out_phase <= RESET_OUTPUT_PHASE[3:0];
         input_clock_phase <= 3'h0;
         serialisation_mode <= RESET_SERIALISATION;
         rate_override_enable <= 1'b0;
         rate_override_code <= 3'h0;
         sdio_pulldown_enable <= 1'b1;
         channel_select <= 4'h0;
      end else begin
         stabiliser_enable <= pin_config_mode
                              || !clock_conditioning[POS_STABILISER];
         chop_enable <= enhancement_control[POS_CHOP];
         reduced_range_output <= output_mode_control[POS_REDUCED_RANGE];
         output_invert <= output_mode_control[POS_INVERT];
         twos_complement <= output_mode_control[POS_TWOS];
         termination_select <= output_adjust_control[POS_TERM_LO +: 2];
         frame_clock_out_2x <= output_adjust_control[POS_DRIVE_2X]
                               && device_index_b[POS_FCO_SELECT]
                               && output_adjust_control[POS_TERM_LO +: 2] == 2'h0;
         data_clock_out_2x <= output_adjust_control[POS_DRIVE_2X]
                              && device_index_b[POS_DCO_SELECT]
                              && output_adjust_control[POS_TERM_LO +: 2] == 2'h0;
         data_clock_out_phase <= output_phase_control[POS_OUT_PHASE_LO +: 4];
         input_clock_phase <= output_phase_control[POS_IN_PHASE_LO +: 3];
         serialisation_mode <= serialisation_control;
         // capability limit only; the sample strobe below ignores it
         rate_override_enable <= rate_override_active[POS_OVERRIDE_EN];
         rate_override_code <= rate_override_active[POS_RATE_LO +: 3];
         sdio_pulldown_enable <= !pin_control_two[POS_PULLDOWN_OFF];
         channel_select <= device_index_a[3:0];
      end
   end

   // the divider never sees a phase above its ratio if the host behaves
   acb_sample_divider #(
      .RATIO_WIDTH(3)
   ) u_sample_divider (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(datapath_clock_enable),
      .hold_reset(datapath_reset),
      .ratio(clock_divider[2:0]),
      .phase(input_clock_phase),
      .sample_strobe(sample_strobe)
   );
endmodule // acb_config_bank
`default_nettype wire

// [bench/acb_config_bank_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic spi_csb_n,
   input wire logic spi_sdio_oe,
   input wire logic power_down_pin,
   input wire logic pin_config_mode,
   input wire logic datapath_clock_enable,
   input wire logic datapath_reset,
   input wire logic outputs_enable,
   input wire logic stabiliser_enable,
   input wire logic output_invert,
   input wire logic twos_complement,
   input wire logic [1:0] termination_select,
   input wire logic frame_clock_out_2x,
   input wire logic data_clock_out_2x,
   input wire logic [3:0] data_clock_out_phase,
   input wire logic [7:0] serialisation_mode,
   input wire logic rate_override_enable,
   input wire logic [2:0] rate_override_code
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // five idle cycles cover the write landing and the decode lag
   sequence port_quiet;
      spi_csb_n [*5];
   endsequence
   quiet_config_a: assert property (port_quiet |-> $stable({output_invert, twos_complement,
      termination_select, data_clock_out_phase, serialisation_mode}))
      else $error("config output moved with port idle");
   quiet_override_a: assert property (port_quiet |->
      $stable({rate_override_enable, rate_override_code})) else $error("override moved");
   pin_quiets_a: assert property (power_down_pin |=> !outputs_enable)
      else $error("outputs on with pin high");
   outputs_gate_a: assert property (outputs_enable |-> datapath_clock_enable && !datapath_reset)
      else $error("outputs on outside normal mode");
   port_release_a: assert property (spi_csb_n |=> !spi_sdio_oe)
      else $error("data pin driven while deselected");
   pin_stabiliser_a: assert property (pin_config_mode |=> stabiliser_enable)
      else $error("stabiliser off under pin configuration");
   reset_defaults_a: assert property ($fell(rst) |-> twos_complement &&
      data_clock_out_phase == 4'h3 && serialisation_mode == 8'h30) else $error("bad defaults");
   term_wins_a: assert property (termination_select != 2'h0 |->
      !frame_clock_out_2x && !data_clock_out_2x) else $error("2x drive with termination");
   phase_range_a: assert property (data_clock_out_phase <= 4'hB)
      else $error("data clock phase beyond range");
endmodule // acb_config_bank_chk
bind acb_config_bank acb_config_bank_chk i_chk (.sys_clk, .rst, .spi_csb_n, .spi_sdio_oe,
   .power_down_pin, .pin_config_mode, .datapath_clock_enable, .datapath_reset, .outputs_enable,
   .stabiliser_enable, .output_invert, .twos_complement, .termination_select,
   .frame_clock_out_2x, .data_clock_out_2x, .data_clock_out_phase, .serialisation_mode,
   .rate_override_enable, .rate_override_code);
`default_nettype wire

// [bench/acb_host.sv]
`timescale 1ns/10ps
`default_nettype none
module acb_host (
   input wire logic sys_clk,
   input wire logic spi_sdio_out,
   input wire logic spi_sdio_oe,
   output logic spi_sclk,
   output logic spi_csb_n,
   output logic spi_sdio_in
);
   logic drive_bit = 1'b0;
   logic host_en = 1'b1;
   // a released line shows the inverse of the last bit, never a stale copy
   assign spi_sdio_in = host_en ? drive_bit : (spi_sdio_oe ? spi_sdio_out : ~drive_bit);
   initial begin
      spi_sclk = 1'b0;
      spi_csb_n = 1'b1;
   end
   task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
      logic [23:0] sh;
      sh = {ins, wd};
      rd = 8'h00;
      @(posedge sys_clk) spi_csb_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge sys_clk) spi_sclk <= 1'b0;
         host_en <= !(ins[15] && i < 8);
         if (!(ins[15] && i < 8)) drive_bit <= sh[i];
         repeat (2) @(posedge sys_clk);
         spi_sclk <= 1'b1;
         // sampled late in the high phase, clear of the synchroniser lag
         @(posedge sys_clk);
         if (i < 8) rd[i] = spi_sdio_in;
      end
      @(posedge sys_clk) spi_sclk <= 1'b0;
      host_en <= 1'b1;
      @(posedge sys_clk) spi_csb_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // acb_host
`default_nettype wire

// [bench/acb_config_bank_test.sv]
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank_test;
   import acb_pkg::*;
   logic sys_clk, rst, power_down_pin, pin_config_mode, spi_sclk, spi_csb_n, spi_sdio_in;
   logic spi_sdio_out, spi_sdio_oe, datapath_clock_enable, datapath_reset, outputs_enable;
   logic stabiliser_enable, chop_enable, reduced_range_output, output_invert, twos_complement;
   logic frame_clock_out_2x, data_clock_out_2x, sample_strobe, rate_override_enable;
   logic sdio_pulldown_enable;
   logic [1:0] termination_select;
   logic [3:0] data_clock_out_phase, channel_select;
   logic [2:0] input_clock_phase, rate_override_code;
   logic [7:0] serialisation_mode, rd, cnt;
   int error_cnt = 0;
   int num_checks = 0;
   logic [12:0] adr [10] = '{ADDR_POWER_MODE, ADDR_CLOCK_COND, ADDR_ENHANCEMENT,
      ADDR_OUTPUT_MODE, ADDR_OUTPUT_ADJUST, ADDR_OUTPUT_PHASE, ADDR_SERIALISATION,
      ADDR_RATE_OVERRIDE, ADDR_PIN_CONTROL_TWO, 13'h000A};
   logic [7:0] rv [10] = '{RESET_POWER_MODE, RESET_CLOCK_COND, RESET_ENHANCEMENT,
      RESET_OUTPUT_MODE, RESET_OUTPUT_ADJUST, RESET_OUTPUT_PHASE, RESET_SERIALISATION,
      RESET_RATE_OVERRIDE, RESET_PIN_CONTROL_TWO, 8'h00};
   logic [7:0] mk [10] = '{MASK_POWER_MODE, MASK_CLOCK_COND, MASK_ENHANCEMENT,
      MASK_OUTPUT_MODE, MASK_OUTPUT_ADJUST, 8'h73, MASK_SERIALISATION,
      MASK_RATE_OVERRIDE, MASK_PIN_CONTROL_TWO, 8'h00};
   logic [7:0] pw [4] = '{8'h05, 8'h02, 8'h00, 8'h06};
   acb_config_bank i_dut (.sys_clk, .rst, .spi_sclk, .spi_csb_n, .spi_sdio_in, .spi_sdio_out,
      .spi_sdio_oe, .power_down_pin, .pin_config_mode, .datapath_clock_enable,
      .datapath_reset, .outputs_enable, .stabiliser_enable, .chop_enable,
      .reduced_range_output, .output_invert, .twos_complement, .termination_select,
      .frame_clock_out_2x, .data_clock_out_2x, .data_clock_out_phase, .input_clock_phase,
      .sample_strobe, .serialisation_mode, .rate_override_enable, .rate_override_code,
      .sdio_pulldown_enable, .channel_select);
   acb_host i_host (.sys_clk, .spi_sdio_out, .spi_sdio_oe, .spi_sclk, .spi_csb_n,
      .spi_sdio_in);
   task automatic chk(input string n, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      i_host.xfer({3'b000, a}, d, rd);
   endtask
   task automatic rc(input logic [12:0] a, input logic [7:0] e);
      i_host.xfer({3'b100, a}, 8'h00, rd);
      chk($sformatf("read %h", a), e, rd);
   endtask
   task automatic conclude;
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [7:0] pwr_bits();
      return {5'h0, datapath_clock_enable, datapath_reset, outputs_enable};
   endfunction
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // a run of about 8k cycles; the margin covers slow port timing
   initial begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      power_down_pin = 1'b0;
      pin_config_mode = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("stabiliser", 8'h00, {7'h0, stabiliser_enable});
      pin_config_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("stabiliser pin", 8'h01, {7'h0, stabiliser_enable});
      pin_config_mode <= 1'b0;
      rc(ADDR_UPDATE_COMMIT, 8'h00);
      for (int i = 0; i < 10; i++) begin
         rc(adr[i], rv[i]);
         wr(adr[i], 8'hFF);
         rc(adr[i], mk[i]);
         wr(adr[i], 8'h00);
         rc(adr[i], 8'h00);
      end
      chk("stabiliser on", 8'h01, {7'h0, stabiliser_enable});
      chk("pull-down", 8'h01, {7'h0, sdio_pulldown_enable});
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_POWER_MODE, 8'(m));
         chk("power", pw[m], pwr_bits());
      end
      rc(ADDR_POWER_MODE, 8'h03);
      wr(ADDR_POWER_MODE, 8'h00);
      power_down_pin <= 1'b1;
      wr(ADDR_POWER_MODE, 8'h20);
      chk("pin standby", 8'h00, pwr_bits());
      wr(ADDR_POWER_MODE, 8'h00);
      chk("pin power-down", 8'h02, pwr_bits());
      power_down_pin <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_OUTPUT_MODE, (k == 0) ? 8'h40 : 8'h04 >> (2 * (k - 1)));
         chk("out mode", 8'h04 >> k,
            {5'h0, reduced_range_output, output_invert, twos_complement});
      end
      wr(ADDR_ENHANCEMENT, 8'h04);
      chk("chop", 8'h01, {7'h0, chop_enable});
      wr(ADDR_SERIALISATION, 8'h34);
      chk("serial mode", 8'h34, serialisation_mode);
      wr(ADDR_OUTPUT_ADJUST, 8'h01);
      chk("drive 2x", 8'h03, {6'h0, frame_clock_out_2x, data_clock_out_2x});
      wr(ADDR_DEVICE_INDEX_B, 8'h2F);
      chk("drive frame", 8'h02, {6'h0, frame_clock_out_2x, data_clock_out_2x});
      chk("channel select", 8'h0F, {4'h0, channel_select});
      wr(ADDR_OUTPUT_ADJUST, 8'h21);
      chk("termination", 8'h08,
         {4'h0, termination_select, frame_clock_out_2x, data_clock_out_2x});
      wr(ADDR_CLOCK_DIVIDER, 8'h07);
      wr(ADDR_OUTPUT_PHASE, 8'h7B);
      chk("phase", 8'h7B, {1'b0, input_clock_phase, data_clock_out_phase});
      wr(ADDR_OUTPUT_PHASE, 8'h5C);
      chk("phase limit", 8'h5B, {1'b0, input_clock_phase, data_clock_out_phase});
      cnt = 8'h00;
      repeat (32) @(posedge sys_clk) cnt = cnt + {7'h0, sample_strobe};
      chk("strobes", 8'h04, cnt);
      wr(ADDR_RATE_OVERRIDE, 8'h45);
      chk("override staged", 8'h00, {4'h0, rate_override_enable, rate_override_code});
      wr(ADDR_UPDATE_COMMIT, 8'h01);
      chk("override live", 8'h0D, {4'h0, rate_override_enable, rate_override_code});
      wr(ADDR_PIN_CONTROL_TWO, 8'h01);
      chk("pull-down off", 8'h00, {7'h0, sdio_pulldown_enable});
      conclude();
   end
endmodule // acb_config_bank_test
`default_nettype wire
